/* dv/lbcs_far_model.sv */
// Local arbiter and target model facing the local bus control block.
// Assumes pull-ups on the shared pins are resolved by the bench.
`timescale 1ns/1ns
`default_nettype none

module lbcs_far_model (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic slow,
	input  wire logic inhibit,
	input  wire logic hold_request,
	input  wire logic local_bus_request_n,
	output logic      hold_acknowledge,
	output logic      local_bus_grant_n,
	output logic      burst_inhibit_n,
	output logic      local_ready_n
);
	logic [1:0] cnt_q;
	logic       gnt_q;
	logic       req;

	assign req = hold_request || !local_bus_request_n;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 2'h0;
			gnt_q <= 1'h0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			gnt_q <= req && (gnt_q || !slow || cnt_q == 2'h3);
		end
	end
	// Grant only while the request stands
	assign hold_acknowledge  = hold_request && gnt_q;
	assign local_bus_grant_n = !(!local_bus_request_n && gnt_q);
	assign burst_inhibit_n   = !(inhibit && !local_bus_request_n);
	// Slow target is not ready on every other clock
	assign local_ready_n     = slow && cnt_q[0];
endmodule : lbcs_far_model

`default_nettype wire

/* dv/lbcs_monitor.sv */
// Checker of the local bus control pins, bound to the top module.
// Assumes the top module port names and one clock domain.
`timescale 1ns/1ns
`default_nettype none

module lbcs_monitor (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        addr_strobe_n,
	input wire logic        addr_latch,
	input wire logic        burst_last_n,
	input wire logic        burst_last_oe,
	input wire logic        hold_request,
	input wire logic        local_bus_grant_n,
	input wire logic        local_bus_busy_in_n,
	input wire logic        local_bus_busy_oe,
	input wire logic        burst_data_pending_n,
	input wire logic        burst_data_pending_oe,
	input wire logic        bus_request_out,
	input wire logic        dm_pending,
	input wire logic        xfer_done,
	input wire logic [31:0] ad,
	input wire logic [3:0]  cbe_n,
	input wire logic        pci_addr_phase,
	input wire logic        par
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_strobe_one_clk: assert property (!addr_strobe_n |=> addr_strobe_n)
		else $error("address strobe longer than one clock");
	a_latch_in_addr: assert property (addr_latch |-> !addr_strobe_n)
		else $error("latch pulse outside address phase");
	a_latch_pulse: assert property (addr_latch |=> !addr_latch)
		else $error("latch pulse runs into data phase");
	a_busy_after_grant: assert property ($rose(local_bus_busy_oe) |->
		!$past(local_bus_grant_n) && $past(local_bus_busy_in_n))
		else $error("busy driven without grant or while busy");
	a_hold_for_strobe: assert property ($fell(addr_strobe_n) |-> hold_request)
		else $error("strobe without hold request");
	a_mode_pins: assert property (local_bus_busy_oe |->
		addr_strobe_n && !hold_request && !burst_last_oe)
		else $error("pins of two modes active together");
	a_even_parity: assert property ($past(pci_addr_phase) |->
		par == (^$past(ad) ^ ^$past(cbe_n)))
		else $error("address parity not even");
	a_last_marked: assert property (xfer_done && $past(burst_last_oe, 2)
		|-> !$past(burst_last_n, 2))
		else $error("final transfer without burst last");
	a_pending_drop: assert property (xfer_done
		&& $past(burst_data_pending_oe, 2) |-> $past(burst_data_pending_n, 2))
		else $error("data pending held in last beat");
	a_breq_cause: assert property (bus_request_out |-> dm_pending)
		else $error("request out without pending master");

	c_strobe: cover property ($fell(addr_strobe_n));
	c_busy: cover property ($rose(local_bus_busy_oe));
	c_latch: cover property (addr_latch);
endmodule : lbcs_monitor

bind lbcs_local_ctrl lbcs_monitor u_mon (.*);

`default_nettype wire

/* dv/test_local_bus_control_signaling.sv */
// Self-checking bench for the local bus control block.
// Assumes the far model answers arbitration; pull-ups on shared pins.
`timescale 1ns/1ns
`default_nettype none

module test_local_bus_control_signaling;
	logic core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, ad = 32'h0, reg_rdata, d;
	logic [1:0] mode_strap = 2'h0, m;
	logic [3:0] xfer_beats = 4'h2, cbe_n = 4'hf;
	logic xfer_req = 1'h0, xfer_write = 1'h0, xfer_dma = 1'h0;
	logic xfer_ds = 1'h0, dm_pending = 1'h0, bus_request_in = 1'h0;
	logic big_endian_select_n = 1'h1, slave_sel = 1'h0, trdy_n = 1'h1;
	logic slave_addr_phase = 1'h0, pci_addr_phase = 1'h0, irdy_n = 1'h1;
	logic pci_write = 1'h0, slow = 1'h0, inhib = 1'h0, tk, ok, cj;
	logic xfer_ack, xfer_beat, xfer_done, xfer_is_write, big_endian;
	logic addr_strobe_n, addr_latch, burst_last_n, burst_last_oe;
	logic hold_request, hold_acknowledge, bus_request_out, local_ready_n;
	logic local_bus_request_n, local_bus_grant_n, burst_inhibit_n;
	logic local_bus_busy_n, local_bus_busy_oe, local_bus_busy_in_n;
	logic burst_data_pending_n, burst_data_pending_oe, burst_last_in_n;
	logic burst_data_pending_in_n, wait_stall_n, wait_stall_oe;
	logic wait_stall_in_n, slave_ack, slave_last, par, par_oe;
	logic [1:0] md [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h3};
	int n_errors = 0, total_checks = 0, nb, nd, ns, nl, sh, sb, sp, sl, sr;

	// Pull-ups on shared pins
	assign local_bus_busy_in_n = !(local_bus_busy_oe && !local_bus_busy_n);
	assign burst_data_pending_in_n = !(burst_data_pending_oe
		&& !burst_data_pending_n);
	assign wait_stall_in_n = !(wait_stall_oe && !wait_stall_n);
	assign burst_last_in_n = !(burst_last_oe && !burst_last_n);

	lbcs_local_ctrl #(.BEAT_W(4)) u_dut (.*);
	lbcs_far_model u_far (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
		.inhibit(inhib), .hold_request(hold_request),
		.local_bus_request_n(local_bus_request_n),
		.hold_acknowledge(hold_acknowledge),
		.local_bus_grant_n(local_bus_grant_n),
		.burst_inhibit_n(burst_inhibit_n), .local_ready_n(local_ready_n));

	initial forever #2 core_clk = ~core_clk;

	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [31:0] e, s);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic run_xfer;
		{nb, nd, ns, nl, sh, sb, sp, sl, sr} = '0;
		@(posedge core_clk);
		xfer_req <= 1'h1;
		#1 tk = xfer_req && xfer_ack === 1'h1;
		for (int k = 0; k < 60 && nd == 0; k++) begin
			@(posedge core_clk);
			if (tk) xfer_req <= 1'h0;
			#1 tk = xfer_req && xfer_ack === 1'h1;
			nb += (xfer_beat === 1'h1);
			nd += (xfer_done === 1'h1);
			ns += (addr_strobe_n === 1'h0);
			nl += (addr_latch === 1'h1);
			sh |= (hold_request === 1'h1);
			sb |= (local_bus_busy_oe === 1'h1);
			sp |= (burst_data_pending_oe === 1'h1);
			sl |= (burst_last_oe === 1'h1 && burst_last_n === 1'h0);
			sr |= (bus_request_out === 1'h1);
		end
		@(posedge core_clk);
		xfer_req <= 1'h0;
	endtask : run_xfer

	initial begin
		for (int i = 0; i < 5; i++) begin
			m = md[i];
			ok = m != 2'h2;
			cj = !m[1];
			mode_strap <= m;
			slow <= i[0];
			inhib <= (i == 4);
			big_endian_select_n <= (i != 2);
			xfer_write <= i[0];
			xfer_dma <= i[1];
			xfer_ds <= i[0];
			dm_pending <= !i[1];
			rst_n <= 1'h0;
			repeat (10) @(posedge core_clk);
			rst_n <= 1'h1;
			repeat (3) @(posedge core_clk);
			rd(lbcs_pkg::LBCS_OFF_STATUS);
			chk("status mode", {1'h1, m}, d & 32'h7);
			run_xfer();
			chk("done", ok, nd);
			chk("beats", ok ? 32'h2 : 32'h0, nb);
			chk("strobe cycles", ok && cj, ns);
			chk("latch cycles", m == 2'h1, nl);
			chk("hold seen", ok && cj, sh);
			chk("busy seen", ok && !cj, sb);
			chk("pending seen", i == 3, sp);
			chk("last seen", ok && cj, sl);
			chk("request out", i == 1, sr);
			chk("endian pin", i == 2, big_endian);
		end
		rd(lbcs_pkg::LBCS_OFF_CTRL);
		chk("ctrl reset", 32'h08, d);
		wr(lbcs_pkg::LBCS_OFF_CTRL, 32'h09);
		rd(lbcs_pkg::LBCS_OFF_CTRL);
		chk("ctrl", 32'h09, d);
		rd(8'h10);
		chk("unmapped", 32'h0, d);
		run_xfer();
		chk("endian cfg", 1'h1, big_endian);
		@(posedge core_clk);
		slave_sel <= 1'h1;
		#1 chk("slave ack", 1'h1, slave_ack);
		chk("slave last", 1'h1, slave_last);
		@(posedge core_clk);
		slave_sel <= 1'h0;
		for (int j = 0; j < 2; j++) begin
			@(posedge core_clk);
			ad <= j ? 32'h00000001 : 32'h12345670;
			cbe_n <= j ? 4'h7 : 4'h6;
			pci_addr_phase <= (j == 0);
			trdy_n <= (j == 0);
			@(posedge core_clk);
			pci_addr_phase <= 1'h0;
			trdy_n <= 1'h1;
			#1 chk("parity", ^{ad, cbe_n}, par);
			chk("parity enable", 1'h1, par_oe);
		end
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		give_verdict();
	end
endmodule : test_local_bus_control_signaling

`default_nettype wire

/* include/lbcs_pkg.sv */
// Constants and types for the local bus control block.
// Assumes one 250 MHz clock and a plain register port.
//
// Functional notes
// - Address strobe low only in first clock of each access (C, J).
// - Multiplexed mode: latch pulse high in address phase, low for data.
// - Direct-connect: busy input shows when an external master is done.
// - Drive busy only after grant and while nobody else holds busy.
// - Own bursts: data pending held in data phases, dropped for last.
// - Burst inhibit during request forces single transfers.
// - Big-endian when select pin low in address phase, or by config.
// - Direct-connect with stall selected: drive stall during wait states.
// - As slave in direct-connect, stall input extends the access.
// - Current master marks final transfer with burst last (C, J).
// - If enabled, release the bus in DMA when request input is high (C, J).
// - Request out when direct slave access waits on pending master.
// - Even parity over AD and C/BE, presented one clock after address.
// - Data parity valid one clock after IRDY/TRDY, until phase end+1.
// - Two straps select direct-connect, multiplexed or non-multiplexed.
// - C and J modes request with hold and wait for acknowledge.

package lbcs_pkg;

	typedef enum logic [1:0] {
		LBCS_MODE_C    = 2'b00,
		LBCS_MODE_J    = 2'b01,
		LBCS_MODE_RSVD = 2'b10,
		LBCS_MODE_M    = 2'b11
	} lbcs_mode_t;

	typedef enum logic [2:0] {
		LBCS_ST_IDLE = 3'b000,
		LBCS_ST_ARB  = 3'b001,
		LBCS_ST_ADDR = 3'b010,
		LBCS_ST_DATA = 3'b011,
		LBCS_ST_REL  = 3'b100
	} lbcs_state_t;

	localparam logic [7:0] LBCS_OFF_CTRL   = 8'h00;
	localparam logic [7:0] LBCS_OFF_STATUS = 8'h04;

	localparam int LBCS_CTRL_BIG_END  = 0;
	localparam int LBCS_CTRL_BREQ_REL = 1;
	localparam int LBCS_CTRL_STALL    = 2;
	localparam int LBCS_CTRL_BURST    = 3;
	localparam int LBCS_CTRL_WAIT_LSB = 4;
	localparam int LBCS_WAIT_W        = 4;

	localparam logic [7:0] LBCS_CTRL_RESET = 8'h08;

endpackage : lbcs_pkg

/* logic/lbcs_local_ctrl.sv */
// Local bus control signalling: arbitration, strobes, burst marks.
// Assumes local bus pins synchronous to core_clk; pull-ups outside.
`timescale 1ns/1ns
`default_nettype none

module lbcs_local_ctrl #(
	parameter int BEAT_W = 4
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	input  wire logic [1:0]        mode_strap,
	input  wire logic              xfer_req,
	input  wire logic              xfer_write,
	input  wire logic [BEAT_W-1:0] xfer_beats,
	input  wire logic              xfer_dma,
	input  wire logic              xfer_ds,
	input  wire logic              dm_pending,
	output logic                   xfer_ack,
	output logic                   xfer_beat,
	output logic                   xfer_done,
	output logic                   xfer_is_write,
	output logic                   big_endian,
	output logic                   addr_strobe_n,
	output logic                   addr_latch,
	input  wire logic              burst_last_in_n,
	output logic                   burst_last_n,
	output logic                   burst_last_oe,
	output logic                   hold_request,
	input  wire logic              hold_acknowledge,
	input  wire logic              bus_request_in,
	output logic                   bus_request_out,
	output logic                   local_bus_request_n,
	input  wire logic              local_bus_grant_n,
	input  wire logic              burst_inhibit_n,
	input  wire logic              local_bus_busy_in_n,
	output logic                   local_bus_busy_n,
	output logic                   local_bus_busy_oe,
	input  wire logic              burst_data_pending_in_n,
	output logic                   burst_data_pending_n,
	output logic                   burst_data_pending_oe,
	input  wire logic              wait_stall_in_n,
	output logic                   wait_stall_n,
	output logic                   wait_stall_oe,
	input  wire logic              local_ready_n,
	input  wire logic              big_endian_select_n,
	input  wire logic              slave_sel,
	input  wire logic              slave_addr_phase,
	output logic                   slave_ack,
	output logic                   slave_last,
	input  wire logic [31:0]       ad,
	input  wire logic [3:0]        cbe_n,
	input  wire logic              pci_addr_phase,
	input  wire logic              pci_write,
	input  wire logic              irdy_n,
	input  wire logic              trdy_n,
	output logic                   par,
	output logic                   par_oe
);

	initial begin
		if (BEAT_W < 1 || BEAT_W > 16) begin
			$error("BEAT_W out of range");
		end
	end

	typedef struct packed {
		lbcs_pkg::lbcs_state_t      st;
		lbcs_pkg::lbcs_mode_t       mode;
		logic                       mode_ok;
		logic [7:0]                 ctrl;
		logic [BEAT_W-1:0]          left;
		logic [lbcs_pkg::LBCS_WAIT_W-1:0] wcnt;
		logic                       single;
		logic                       dma;
		logic                       ds;
		logic                       wr;
		logic                       be;
		logic                       beat;
		logic                       done;
		logic [31:0]                rdata;
	} lbcs_ctrl_state_t;

	lbcs_ctrl_state_t q, d;
	logic             rst_s1_q;
	logic             rst_s2_q;
	logic             is_m;
	logic             is_cj;
	logic             usable;
	logic             owns_data;
	logic             last_beat;
	logic             ctrl_burst;
	logic             ctrl_stall;
	logic [lbcs_pkg::LBCS_WAIT_W-1:0] ctrl_wait;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// Mode decode gates which pin set is alive
	assign is_m   = q.mode_ok && q.mode == lbcs_pkg::LBCS_MODE_M;
	assign is_cj  = q.mode_ok && (q.mode == lbcs_pkg::LBCS_MODE_C ||
		q.mode == lbcs_pkg::LBCS_MODE_J);
	assign usable = is_m || is_cj;

	assign ctrl_burst = q.ctrl[lbcs_pkg::LBCS_CTRL_BURST];
	assign ctrl_stall = q.ctrl[lbcs_pkg::LBCS_CTRL_STALL];
	assign ctrl_wait  = q.ctrl[lbcs_pkg::LBCS_CTRL_WAIT_LSB +:
		lbcs_pkg::LBCS_WAIT_W];

	assign owns_data = q.st == lbcs_pkg::LBCS_ST_DATA;
	assign last_beat = q.single || q.left == BEAT_W'(1);

	always_comb begin
		d = q;
		d.beat  = 1'b0;
		d.done  = 1'b0;
		d.rdata = 32'h0;

		// Straps taken once after reset release
		if (!q.mode_ok) begin
			d.mode    = lbcs_pkg::lbcs_mode_t'({mode_strap[1],
				mode_strap[0]});
			d.mode_ok = 1'b1;
		end

		// Register port
		if (reg_wr && reg_addr == lbcs_pkg::LBCS_OFF_CTRL) begin
			d.ctrl = reg_wdata[7:0];
		end
		if (reg_rd) begin
			unique case (reg_addr)
				lbcs_pkg::LBCS_OFF_CTRL: begin
					d.rdata = {24'h0, q.ctrl};
				end
				lbcs_pkg::LBCS_OFF_STATUS: begin
					d.rdata = {22'h0, q.st, ~burst_data_pending_in_n,
						q.be, ~local_bus_busy_in_n & ~local_bus_busy_oe,
						owns_data, q.mode_ok, q.mode};
				end
				default: begin
					d.rdata = 32'h0;
				end
			endcase
		end

		// Slave side address phase also picks byte order
		if (slave_addr_phase) begin
			d.be = ~big_endian_select_n |
				q.ctrl[lbcs_pkg::LBCS_CTRL_BIG_END];
		end

		unique case (q.st)
			lbcs_pkg::LBCS_ST_IDLE: begin
				if (xfer_req && usable) begin
					d.left = (xfer_beats == '0) ? BEAT_W'(1) : xfer_beats;
					d.wr   = xfer_write;
					d.dma  = xfer_dma;
					d.ds   = xfer_ds;
					d.st   = lbcs_pkg::LBCS_ST_ARB;
				end
			end
			lbcs_pkg::LBCS_ST_ARB: begin
				if (is_m) begin
					// Take the bus only when granted and busy is free
					if (!local_bus_grant_n && local_bus_busy_in_n) begin
						d.single = ~ctrl_burst | ~burst_inhibit_n;
						d.st     = lbcs_pkg::LBCS_ST_ADDR;
					end
				end else if (hold_acknowledge) begin
					d.single = ~ctrl_burst;
					d.st     = lbcs_pkg::LBCS_ST_ADDR;
				end
			end
			lbcs_pkg::LBCS_ST_ADDR: begin
				d.be   = ~big_endian_select_n |
					q.ctrl[lbcs_pkg::LBCS_CTRL_BIG_END];
				d.wcnt = ctrl_wait;
				d.st   = lbcs_pkg::LBCS_ST_DATA;
			end
			lbcs_pkg::LBCS_ST_DATA: begin
				if (q.wcnt != '0) begin
					d.wcnt = q.wcnt - 1'b1;
				end else if (!local_ready_n) begin
					d.beat = 1'b1;
					d.left = q.left - 1'b1;
					d.wcnt = ctrl_wait;
					if (q.left == BEAT_W'(1)) begin
						d.st = lbcs_pkg::LBCS_ST_REL;
					end else if (is_cj && q.dma && bus_request_in &&
						q.ctrl[lbcs_pkg::LBCS_CTRL_BREQ_REL]) begin
						d.st = lbcs_pkg::LBCS_ST_REL;
					end else if (q.single) begin
						d.st = lbcs_pkg::LBCS_ST_ADDR;
					end
				end
			end
			lbcs_pkg::LBCS_ST_REL: begin
				if (q.left == '0) begin
					d.done = 1'b1;
					d.st   = lbcs_pkg::LBCS_ST_IDLE;
				end else begin
					d.st = lbcs_pkg::LBCS_ST_ARB;
				end
			end
			default: begin
				d.st = lbcs_pkg::LBCS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			q       <= '0;
			q.st    <= lbcs_pkg::LBCS_ST_IDLE;
			q.mode  <= lbcs_pkg::LBCS_MODE_C;
			q.ctrl  <= lbcs_pkg::LBCS_CTRL_RESET;
		end else begin
			q <= d;
		end
	end

	// Request port handshake
	assign xfer_ack      = q.st == lbcs_pkg::LBCS_ST_IDLE &&
		xfer_req && usable;
	assign xfer_beat     = q.beat;
	assign xfer_done     = q.done;
	assign xfer_is_write = q.wr;
	assign big_endian    = q.be;
	assign reg_rdata     = q.rdata;

	// C and J strobes
	assign addr_strobe_n = ~(is_cj &&
		q.st == lbcs_pkg::LBCS_ST_ADDR);
	assign addr_latch    = q.mode_ok &&
		q.mode == lbcs_pkg::LBCS_MODE_J &&
		q.st == lbcs_pkg::LBCS_ST_ADDR;
	assign burst_last_oe = is_cj && (q.st == lbcs_pkg::LBCS_ST_ADDR ||
		owns_data);
	assign burst_last_n  = ~(burst_last_oe && last_beat);

	// C and J arbitration
	assign hold_request    = is_cj &&
		(q.st == lbcs_pkg::LBCS_ST_ARB ||
		q.st == lbcs_pkg::LBCS_ST_ADDR || owns_data);
	assign bus_request_out = is_cj && q.st != lbcs_pkg::LBCS_ST_IDLE &&
		q.ds && dm_pending;

	// Direct-connect arbitration and burst marks
	assign local_bus_request_n = ~(is_m &&
		q.st == lbcs_pkg::LBCS_ST_ARB);
	assign local_bus_busy_oe   = is_m &&
		(q.st == lbcs_pkg::LBCS_ST_ADDR || owns_data);
	assign local_bus_busy_n    = ~local_bus_busy_oe;
	assign burst_data_pending_oe = is_m && owns_data && !q.single;
	assign burst_data_pending_n  = ~(burst_data_pending_oe &&
		!last_beat);
	assign wait_stall_oe = is_m && ctrl_stall && owns_data;
	assign wait_stall_n  = ~(wait_stall_oe && q.wcnt != '0);

	// Slave beats: stall input stretches, pending or last marks the end
	assign slave_ack  = slave_sel && !owns_data &&
		(!is_m || !ctrl_stall || wait_stall_in_n);
	assign slave_last = slave_ack && (is_m ? burst_data_pending_in_n :
		!burst_last_in_n);

	lbcs_parity u_parity (
		.core_clk       (core_clk),
		.rst_n          (rst_s2_q),
		.ad             (ad),
		.cbe_n          (cbe_n),
		.pci_addr_phase (pci_addr_phase),
		.pci_write      (pci_write),
		.irdy_n         (irdy_n),
		.trdy_n         (trdy_n),
		.par            (par),
		.par_oe         (par_oe)
	);

endmodule : lbcs_local_ctrl
`default_nettype wire

/* logic/lbcs_parity.sv */
// PCI parity generator with its valid window.
// Assumes PCI phase signals are synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none

module lbcs_parity (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] ad,
	input  wire logic [3:0]  cbe_n,
	input  wire logic        pci_addr_phase,
	input  wire logic        pci_write,
	input  wire logic        irdy_n,
	input  wire logic        trdy_n,
	output logic             par,
	output logic             par_oe
);

	typedef struct packed {
		logic par;
		logic oe;
	} lbcs_par_state_t;

	lbcs_par_state_t q, d;
	logic            capture;

	// Data phase ready side depends on direction
	always_comb begin
		capture = pci_addr_phase |
			(pci_write ? ~irdy_n : ~trdy_n);
		d = q;
		d.oe = capture;
		if (capture) begin
			d.par = ^{ad, cbe_n};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign par    = q.par;
	assign par_oe = q.oe;

endmodule : lbcs_parity
`default_nettype wire
